// >>> hw/ptm_timer.sv
// Summary of operation
// [R1] Up-counter, 10 or 16 bits wide, advanced by the selected clock tick.
// [R2] Comparators A and P compare full width against the whole counter.
// [R3] Counter is not writable; a run rising edge clears it.
// [R4] Overflow or selected compare match clears the counter; only a compare match raises request, overflow alone sets no flag.
// [R5] Counter readable as read-only low and high byte pair.
// [R6] Compare A and P held in writable byte pairs, reset to zero.
// [R7] Unimplemented high bits and control 0 bits 2..0 read zero.
// [R8] Pause bit freezes counter; clearing resumes from held value.
// [R9] Clock select: sys/4, sys, high/16, high/64, sub, pin rise, pin fall.
// [R10] Run bit low stops counting; high lets counter run.
// [R11] Run fall keeps residual count; next rise zeroes it.
// [R12] Run rise sets output pin to initial level in output modes.
// [R13] Four modes, one external clock input, one output pin.
// [R14] Software routes shared pins to the timer before use.
// [R15] Mode field: 00 compare, 01 undefined, 10 PWM/pulse, 11 timer.
// [R16] Output function field per mode: compare actions or PWM controls.
// [R17] Clear select: 1 clears on A, 0 on P or overflow if P zero; PWM mode always clears on P.
// [R18] Invert bit inverts output pin, ignored in timer mode.
// [R19] External pin synchronised, selected edge advances the counter.
// [R20] Counter equal to nonzero compare value sets that comparator flag; P sets none if clear select is 1 outside PWM mode.
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ptm_defs.svh"

module ptm_timer #(
    parameter int CNT_W = 16
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        timerClockPin,
    output logic             timerOutputPin,
    output logic             timerIrq
);

    logic [7:0]       ctrl0;
    logic [7:0]       ctrl1;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] cmpA;
    logic [CNT_W-1:0] cmpP;
    logic             flagA;
    logic             flagP;
    logic             outLevel;
    logic             runLast;
    logic             wrPend;
    logic [11:0]      wrAddr;
    logic [7:0]       next_ctrl0;
    logic [7:0]       next_ctrl1;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] next_cmpA;
    logic [CNT_W-1:0] next_cmpP;
    logic             next_flagA;
    logic             next_flagP;
    logic             next_outLevel;
    logic             next_timerOutputPin;
    logic             next_timerIrq;
    logic             next_wrPend;
    logic [11:0]      next_wrAddr;
    logic [31:0]      next_hrdata;
    logic             tick;
    logic             runOn;
    logic             runRise;
    logic             matchA;
    logic             matchP;
    logic             overflow;
    logic             clearEv;
    logic             evA;
    logic             evP;
    logic             singlePulse;
    logic             pwmPhase;
    logic [1:0]       mode;
    logic [1:0]       ioSel;
    logic             addrPhase;
    logic [15:0]      cntWide;
    logic [15:0]      aWide;
    logic [15:0]      pWide;

    assign runOn       = ctrl0[`PTM_C0_RUN];
    assign runRise     = runOn & ~runLast;
    assign mode        = ctrl1[`PTM_C1_MODE_HI:`PTM_C1_MODE_LO];
    assign ioSel       = ctrl1[`PTM_C1_IO_HI:`PTM_C1_IO_LO];
    assign singlePulse = (mode == ptm_pkg::PTM_MODE_PWM) && (ioSel == 2'b11);
    assign addrPhase   = hsel & hready & htrans[1];
    assign cntWide     = 16'(count);
    assign aWide       = 16'(cmpA);
    assign pWide       = 16'(cmpP);

    // [R13] [R9] Prescaler and pin clock source
    ptm_clock_gen u_clk (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .clkSel  (ctrl0[`PTM_C0_CKSEL_HI:`PTM_C0_CKSEL_LO]),
        .pinIn   (timerClockPin),
        .tick    (tick)
    );

    // [R2] Full-width compare
    assign matchA   = (count == cmpA);
    assign matchP   = (count == cmpP);
    assign overflow = (count == {CNT_W{1'b1}});
    // [R20] Match events on counting tick
    assign evA = tick & runOn & ~ctrl0[`PTM_C0_PAUSE] & ~runRise & matchA & (cmpA != '0);
    assign evP = tick & runOn & ~ctrl0[`PTM_C0_PAUSE] & ~runRise & matchP & (cmpP != '0)
                 & (~ctrl1[`PTM_C1_CCLR] | (mode == ptm_pkg::PTM_MODE_PWM));
    // [R17] Clear source selection
    always_comb begin
        if (mode == ptm_pkg::PTM_MODE_PWM) begin
            clearEv = evP | (overflow & (cmpP == '0));
        end else if (ctrl1[`PTM_C1_CCLR]) begin
            clearEv = evA | (overflow & (cmpA == '0));
        end else begin
            clearEv = evP | (overflow & (cmpP == '0));
        end
    end

    assign pwmPhase = (count < cmpA);

    always_comb begin
        next_ctrl0    = ctrl0;
        next_ctrl1    = ctrl1;
        next_cmpA     = cmpA;
        next_cmpP     = cmpP;
        next_count    = count;
        next_outLevel = outLevel;
        next_flagA    = flagA;
        next_flagP    = flagP;
        next_wrPend   = addrPhase & hwrite;
        next_wrAddr   = addrPhase ? haddr : wrAddr;
        // [R6] Control, compare byte pair and flag clear writes
        if (wrPend) begin
            unique case (wrAddr)
                `PTM_OFF_CTRL0:   next_ctrl0 = hwdata[7:0] & `PTM_C0_MASK;
                `PTM_OFF_CTRL1:   next_ctrl1 = hwdata[7:0];
                `PTM_OFF_CMPA_LO: next_cmpA[7:0] = hwdata[7:0];
                `PTM_OFF_CMPA_HI: next_cmpA[CNT_W-1:8] = hwdata[CNT_W-9:0];
                `PTM_OFF_CMPP_LO: next_cmpP[7:0] = hwdata[7:0];
                `PTM_OFF_CMPP_HI: next_cmpP[CNT_W-1:8] = hwdata[CNT_W-9:0];
                `PTM_OFF_FLAGS: begin
                    next_flagA = flagA & ~hwdata[`PTM_FL_A];
                    next_flagP = flagP & ~hwdata[`PTM_FL_P];
                end
                default: ;
            endcase
        end
        // [R4] Set wins over clear
        if (evA) begin
            next_flagA = 1'b1;
        end
        if (evP) begin
            next_flagP = 1'b1;
        end
        // [R3] Run rise zeroes counter
        if (runRise) begin
            next_count = '0;
        // [R10] [R8] Gate by run and pause
        end else if (runOn && !ctrl0[`PTM_C0_PAUSE] && tick) begin
            // [R1] Count up or auto clear
            next_count = clearEv ? '0 : count + 1'b1;
        end
        // Single pulse ends on A match
        if (singlePulse && evA) begin
            next_ctrl0[`PTM_C0_RUN] = 1'b0;
        end
        // [R12] Initial level on run rise
        if (runRise) begin
            next_outLevel = ctrl1[`PTM_C1_INIT];
        // [R16] Compare output actions
        end else if (mode == ptm_pkg::PTM_MODE_CMP && evA) begin
            unique case (ioSel)
                2'b00: next_outLevel = outLevel;
                2'b01: next_outLevel = 1'b0;
                2'b10: next_outLevel = 1'b1;
                2'b11: next_outLevel = ~outLevel;
            endcase
        end
    end

    // [R18] [R15] Pin drive per mode
    always_comb begin
        next_timerOutputPin = outLevel;
        if (mode == ptm_pkg::PTM_MODE_PWM) begin
            unique case (ioSel)
                2'b00: next_timerOutputPin = ~ctrl1[`PTM_C1_INIT];
                2'b01: next_timerOutputPin = ctrl1[`PTM_C1_INIT];
                2'b10: next_timerOutputPin = (pwmPhase & runOn) ? ctrl1[`PTM_C1_INIT] : ~ctrl1[`PTM_C1_INIT];
                2'b11: next_timerOutputPin = runOn ? ctrl1[`PTM_C1_INIT] : ~ctrl1[`PTM_C1_INIT];
            endcase
        end
        if (mode == ptm_pkg::PTM_MODE_TMR) begin
            next_timerOutputPin = 1'b0;
        end else if (ctrl1[`PTM_C1_INV]) begin
            next_timerOutputPin = ~next_timerOutputPin;
        end
        next_timerIrq = next_flagA | next_flagP;
    end

    // [R5] [R7] Read mux
    always_comb begin
        next_hrdata = 32'h0000_0000;
        if (addrPhase && !hwrite) begin
            unique case (haddr)
                `PTM_OFF_CTRL0:   next_hrdata = {24'h000000, ctrl0 & `PTM_C0_MASK};
                `PTM_OFF_CTRL1:   next_hrdata = {24'h000000, ctrl1};
                `PTM_OFF_CNT_LO:  next_hrdata = {24'h000000, cntWide[7:0]};
                `PTM_OFF_CNT_HI:  next_hrdata = {24'h000000, cntWide[15:8]};
                `PTM_OFF_CMPA_LO: next_hrdata = {24'h000000, aWide[7:0]};
                `PTM_OFF_CMPA_HI: next_hrdata = {24'h000000, aWide[15:8]};
                `PTM_OFF_CMPP_LO: next_hrdata = {24'h000000, pWide[7:0]};
                `PTM_OFF_CMPP_HI: next_hrdata = {24'h000000, pWide[15:8]};
                `PTM_OFF_FLAGS:   next_hrdata = {30'h0000_0000, flagP, flagA};
                default:          next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl0          <= `PTM_RESET_BYTE;
            ctrl1          <= `PTM_RESET_BYTE;
            count          <= '0;
            cmpA           <= '0;
            cmpP           <= '0;
            flagA          <= 1'b0;
            flagP          <= 1'b0;
            outLevel       <= 1'b0;
            runLast        <= 1'b0;
            wrPend         <= 1'b0;
            wrAddr         <= 12'h000;
            hrdata         <= 32'h0000_0000;
            hreadyout      <= 1'b1;
            hresp          <= 1'b0;
            timerOutputPin <= 1'b0;
            timerIrq       <= 1'b0;
        end else begin
            ctrl0          <= next_ctrl0;
            ctrl1          <= next_ctrl1;
            count          <= next_count;
            cmpA           <= next_cmpA;
            cmpP           <= next_cmpP;
            flagA          <= next_flagA;
            flagP          <= next_flagP;
            outLevel       <= next_outLevel;
            runLast        <= runOn;
            wrPend         <= next_wrPend;
            wrAddr         <= next_wrAddr;
            hrdata         <= next_hrdata;
            hreadyout      <= 1'b1;
            hresp          <= 1'b0;
            timerOutputPin <= next_timerOutputPin;
            timerIrq       <= next_timerIrq;
        end
    end

    // [R11] Residual held while off
    residual_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !runOn && !runRise |=> $stable(count)) else $error("count moved while off"); // [R11]
    // [R8] Pause freezes counter
    pause_freeze_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ctrl0[`PTM_C0_PAUSE] && !runRise |=> count == $past(count)) else $error("count moved in pause"); // [R8]
    // [R3] Rise clears counter
    rise_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        runRise |=> count == '0) else $error("run rise did not clear"); // [R3]
    // [R12] Rise restores level
    init_level_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        runRise |=> outLevel == $past(ctrl1[`PTM_C1_INIT])) else $error("initial level wrong"); // [R12]
    // [R20] Match sets flag
    match_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        evA |=> flagA && timerIrq) else $error("A flag not raised"); // [R20]
    // [R17] A clear select
    clear_sel_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        evA && ctrl1[`PTM_C1_CCLR] && mode == ptm_pkg::PTM_MODE_CMP |=> count == '0) else $error("A clear missed"); // [R17]
    // [R4] Counter wraps on overflow
    overflow_wrap_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        tick && runOn && !runRise && !ctrl0[`PTM_C0_PAUSE] && overflow |=> count == '0) else $error("no wrap"); // [R4]
    // [R1] Counter steps by one
    count_step_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        tick && runOn && !runRise && !ctrl0[`PTM_C0_PAUSE] && !clearEv |=> count == $past(count) + 1'b1)
        else $error("bad count step"); // [R1]
    // [R7] Reserved control bits zero
    ctrl0_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        ctrl0[2:0] == 3'b000) else $error("control 0 low bits set"); // [R7]
    // [R18] Timer mode pin quiet
    tmr_pin_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        mode == ptm_pkg::PTM_MODE_TMR [*2] |-> !timerOutputPin) else $error("pin driven in timer mode"); // [R18]

    run_rise_c: cover property (@(posedge clk_sys) disable iff (!rstn) runRise ##[1:50] evA);
    overflow_c: cover property (@(posedge clk_sys) disable iff (!rstn) overflow && tick && runOn);
    toggle_c:   cover property (@(posedge clk_sys) disable iff (!rstn) evA && ioSel == 2'b11);

endmodule : ptm_timer
`default_nettype wire

// >>> hw/ptm_defs.svh
`ifndef PTM_DEFS_SVH
`define PTM_DEFS_SVH

// Register byte addresses
`define PTM_OFF_CTRL0     12'h000
`define PTM_OFF_CTRL1     12'h004
`define PTM_OFF_CNT_LO    12'h008
`define PTM_OFF_CNT_HI    12'h00C
`define PTM_OFF_CMPA_LO   12'h010
`define PTM_OFF_CMPA_HI   12'h014
`define PTM_OFF_CMPP_LO   12'h018
`define PTM_OFF_CMPP_HI   12'h01C
`define PTM_OFF_FLAGS     12'h020

// Control 0 fields
`define PTM_C0_PAUSE      7
`define PTM_C0_CKSEL_HI   6
`define PTM_C0_CKSEL_LO   4
`define PTM_C0_RUN        3
`define PTM_C0_MASK       8'hF8

// Control 1 fields
`define PTM_C1_MODE_HI    7
`define PTM_C1_MODE_LO    6
`define PTM_C1_IO_HI      5
`define PTM_C1_IO_LO      4
`define PTM_C1_INIT       3
`define PTM_C1_INV        2
`define PTM_C1_CCLR       0

// Flag register fields
`define PTM_FL_A          0
`define PTM_FL_P          1

`define PTM_RESET_BYTE    8'h00

// Prescaler ratios
`define PTM_DIV_SYS4      4
`define PTM_DIV_H16       16
`define PTM_DIV_H64       64
`define PTM_DIV_SUB       256

`endif

// >>> hw/ptm_pkg.sv
package ptm_pkg;

    typedef enum logic [1:0] {
        PTM_MODE_CMP = 2'b00,
        PTM_MODE_UND = 2'b01,
        PTM_MODE_PWM = 2'b10,
        PTM_MODE_TMR = 2'b11
    } ptm_mode_e;

    typedef enum logic [2:0] {
        PTM_CK_SYS4 = 3'b000,
        PTM_CK_SYS  = 3'b001,
        PTM_CK_H16  = 3'b010,
        PTM_CK_H64  = 3'b011,
        PTM_CK_SUB0 = 3'b100,
        PTM_CK_SUB1 = 3'b101,
        PTM_CK_PINR = 3'b110,
        PTM_CK_PINF = 3'b111
    } ptm_cksel_e;

endpackage : ptm_pkg

// >>> hw/ptm_clock_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptm_defs.svh"

module ptm_clock_gen (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic [2:0] clkSel,
    input  wire logic       pinIn,
    output logic            tick
);

    logic [7:0] divCnt;
    logic [7:0] next_divCnt;
    logic       pinMeta;
    logic       pinSync;
    logic       pinLast;
    logic       next_tick;

    always_comb begin
        next_divCnt = divCnt + 8'h01;
        next_tick   = 1'b0;
        unique case (ptm_pkg::ptm_cksel_e'(clkSel))
            ptm_pkg::PTM_CK_SYS4: next_tick = (divCnt[1:0] == 2'h3);
            ptm_pkg::PTM_CK_SYS:  next_tick = 1'b1;
            ptm_pkg::PTM_CK_H16:  next_tick = (divCnt[3:0] == 4'hF);
            ptm_pkg::PTM_CK_H64:  next_tick = (divCnt[5:0] == 6'h3F);
            ptm_pkg::PTM_CK_SUB0,
            ptm_pkg::PTM_CK_SUB1: next_tick = (divCnt == 8'hFF);
            // [R19] Pin edge detect
            ptm_pkg::PTM_CK_PINR: next_tick = pinSync & ~pinLast;
            ptm_pkg::PTM_CK_PINF: next_tick = ~pinSync & pinLast;
        endcase
    end

    // [R9] Divider, pin synchroniser and tick registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            divCnt  <= 8'h00;
            pinMeta <= 1'b0;
            pinSync <= 1'b0;
            pinLast <= 1'b0;
            tick    <= 1'b0;
        end else begin
            divCnt  <= next_divCnt;
            pinMeta <= pinIn;
            pinSync <= pinMeta;
            pinLast <= pinSync;
            tick    <= next_tick;
        end
    end

endmodule : ptm_clock_gen
`default_nettype wire

// >>> dv/ptm_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module ptm_pin_model #(
    parameter int HALF_NS = 20
) (
    output logic pinOut
);
    initial pinOut = 1'b0;

    task automatic pulses(input int n);
        repeat (n) begin
            #HALF_NS pinOut = 1'b1;
            #HALF_NS pinOut = 1'b0;
        end
    endtask : pulses
endmodule : ptm_pin_model

`default_nettype wire

// >>> dv/tb_periodic_timer_module.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptm_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errTotal++; \
    $display("CHECK FAILED %0t got %0h exp %0h", $time, (g), (e)); end end

module tb_periodic_timer_module;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire         hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        timerClockPin;
    logic        timerOutputPin;
    logic        timerIrq;
    logic [31:0] rd;
    int          errTotal = 0;
    int          checks = 0;

    assign hready = hreadyout;
    always #4 clk_sys = ~clk_sys;

    ptm_timer #(.CNT_W(10)) i_ptm_timer (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timerClockPin(timerClockPin),
        .timerOutputPin(timerOutputPin), .timerIrq(timerIrq));
    ptm_pin_model i_ptm_pin_model (.pinOut(timerClockPin));

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rdChk(input logic [11:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        `CHK(rd, {24'h000000, e})
    endtask : rdChk

    task automatic scn_regs;
        for (int a = 0; a <= 'h20; a += 4) rdChk(12'(a), 8'h00);
        wr(`PTM_OFF_CMPA_LO, 8'hA5);
        wr(`PTM_OFF_CMPA_HI, 8'hFF);
        wr(`PTM_OFF_CMPP_LO, 8'h5A);
        wr(`PTM_OFF_CMPP_HI, 8'hFF);
        rdChk(`PTM_OFF_CMPA_LO, 8'hA5);
        rdChk(`PTM_OFF_CMPA_HI, 8'h03);
        rdChk(`PTM_OFF_CMPP_LO, 8'h5A);
        rdChk(`PTM_OFF_CMPP_HI, 8'h03);
        wr(`PTM_OFF_CTRL0, 8'hF7);
        rdChk(`PTM_OFF_CTRL0, 8'hF0);
        wr(`PTM_OFF_CTRL1, 8'hC5);
        rdChk(`PTM_OFF_CTRL1, 8'hC5);
        wr(`PTM_OFF_CNT_LO, 8'hFF);
        rdChk(`PTM_OFF_CNT_LO, 8'h00);
        wr(12'h040, 8'hFF);
        rdChk(12'h040, 8'h00);
    endtask : scn_regs

    task automatic scn_prescale;
        int divs[6] = '{`PTM_DIV_SYS4, 1, `PTM_DIV_H16, `PTM_DIV_H64, `PTM_DIV_SUB, `PTM_DIV_SUB};
        wr(`PTM_OFF_CMPA_HI, 8'h00);
        wr(`PTM_OFF_CMPA_LO, 8'h00);
        wr(`PTM_OFF_CMPP_HI, 8'h00);
        wr(`PTM_OFF_CMPP_LO, 8'h00);
        wr(`PTM_OFF_CTRL1, 8'hC0);
        for (int s = 0; s < 6; s++) begin
            wr(`PTM_OFF_CTRL0, {1'b0, 3'(s), 4'h0});
            wr(`PTM_OFF_CTRL0, {1'b0, 3'(s), 4'h8});
            cyc(8 * divs[s] + 2);
            wr(`PTM_OFF_CTRL0, {1'b1, 3'(s), 4'h8});
            xfer(1'b0, `PTM_OFF_CNT_LO, 8'h00);
            `CHK(rd >= 8 && rd <= 9 + 6 / divs[s], 1'b1)
        end
    endtask : scn_prescale

    task automatic scn_pause;
        logic [7:0] v;
        wr(`PTM_OFF_CTRL0, 8'h10);
        wr(`PTM_OFF_CTRL0, 8'h18);
        cyc(20);
        wr(`PTM_OFF_CTRL0, 8'h98);
        xfer(1'b0, `PTM_OFF_CNT_LO, 8'h00);
        v = rd[7:0];
        cyc(20);
        rdChk(`PTM_OFF_CNT_LO, v);
        wr(`PTM_OFF_CTRL0, 8'h10);
        cyc(20);
        rdChk(`PTM_OFF_CNT_LO, v);
        wr(`PTM_OFF_CTRL0, 8'h98);
        rdChk(`PTM_OFF_CNT_LO, 8'h00);
        wr(`PTM_OFF_CTRL0, 8'h18);
        cyc(20);
        wr(`PTM_OFF_CTRL0, 8'h98);
        xfer(1'b0, `PTM_OFF_CNT_LO, 8'h00);
        `CHK(rd >= 20 && rd <= 26, 1'b1)
    endtask : scn_pause

    task automatic scn_clear;
        wr(`PTM_OFF_CMPP_LO, 8'h03);
        wr(`PTM_OFF_CTRL0, 8'h10);
        wr(`PTM_OFF_FLAGS, 8'h03);
        wr(`PTM_OFF_CTRL0, 8'h18);
        cyc(20);
        wr(`PTM_OFF_CTRL0, 8'h98);
        xfer(1'b0, `PTM_OFF_CNT_LO, 8'h00);
        `CHK(rd <= 3, 1'b1)
        rdChk(`PTM_OFF_FLAGS, 8'h02);
        `CHK(timerIrq, 1'b1)
        wr(`PTM_OFF_FLAGS, 8'h03);
        rdChk(`PTM_OFF_FLAGS, 8'h00);
        `CHK(timerIrq, 1'b0)
        wr(`PTM_OFF_CTRL1, 8'hC1);
        wr(`PTM_OFF_CMPA_LO, 8'h05);
        wr(`PTM_OFF_CTRL0, 8'h10);
        wr(`PTM_OFF_CTRL0, 8'h18);
        cyc(20);
        wr(`PTM_OFF_CTRL0, 8'h98);
        xfer(1'b0, `PTM_OFF_CNT_LO, 8'h00);
        `CHK(rd <= 5, 1'b1)
        rdChk(`PTM_OFF_FLAGS, 8'h01);
    endtask : scn_clear

    task automatic scn_extclk;
        logic [7:0] c;
        wr(`PTM_OFF_CTRL1, 8'hC0);
        wr(`PTM_OFF_CMPA_LO, 8'h00);
        wr(`PTM_OFF_CMPP_LO, 8'h00);
        for (int e = 0; e < 2; e++) begin
            c = e ? 8'h70 : 8'h60;
            wr(`PTM_OFF_CTRL0, c);
            wr(`PTM_OFF_CTRL0, c | 8'h08);
            i_ptm_pin_model.pulses(5);
            cyc(10);
            wr(`PTM_OFF_CTRL0, c | 8'h88);
            rdChk(`PTM_OFF_CNT_LO, 8'h05);
        end
    endtask : scn_extclk

    task automatic scn_pin;
        logic [7:0] c1[6] = '{8'h21, 8'h19, 8'h1D, 8'h25, 8'h01, 8'h31};
        logic       st[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        logic       en[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
        wr(`PTM_OFF_CMPA_LO, 8'h05);
        for (int i = 0; i < 6; i++) begin
            wr(`PTM_OFF_CTRL0, 8'h10);
            wr(`PTM_OFF_CTRL1, c1[i]);
            wr(`PTM_OFF_CTRL0, 8'h18);
            cyc(3);
            `CHK(timerOutputPin, st[i])
            cyc(12);
            `CHK(timerOutputPin, en[i])
        end
    endtask : scn_pin

    task automatic scn_pwm;
        int n;
        n = 0;
        wr(`PTM_OFF_CTRL0, 8'h10);
        wr(`PTM_OFF_CMPA_LO, 8'h02);
        wr(`PTM_OFF_CMPP_LO, 8'h08);
        wr(`PTM_OFF_CTRL1, 8'hA8);
        wr(`PTM_OFF_CTRL0, 8'h18);
        repeat (72) begin
            @(posedge clk_sys);
            n += timerOutputPin;
        end
        `CHK(n >= 14 && n <= 20, 1'b1)
        wr(`PTM_OFF_CTRL0, 8'h10);
        wr(`PTM_OFF_CTRL1, 8'hB8);
        wr(`PTM_OFF_CMPA_LO, 8'h05);
        wr(`PTM_OFF_CTRL0, 8'h18);
        cyc(2);
        `CHK(timerOutputPin, 1'b1)
        cyc(20);
        rdChk(`PTM_OFF_CTRL0, 8'h10);
        `CHK(timerOutputPin, 1'b0)
    endtask : scn_pwm

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    initial begin
        cyc(8);
        rstn <= 1'b1;
        scn_regs();
        scn_prescale();
        scn_pause();
        scn_clear();
        scn_extclk();
        scn_pin();
        scn_pwm();
        wrap_up();
    end

    initial begin
        #400000;
        errTotal++;
        wrap_up();
    end
endmodule : tb_periodic_timer_module

`default_nettype wire
